// *** hdl/noload_crc_interrupt_unit.sv ***
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Phase idle on every fundamental path with a nonzero limit stops its fundamental accumulation.
// - Zero active or reactive limit leaves that fundamental path unrestricted.
// - Fundamental idle sets second flag bit 1 and phase bits 5:3 together.
// - Fundamental flag sets on any entry or exit; mask bit 1 drives output.
// - Phase with no apparent increments for the limit stops apparent energy.
// - Zero apparent limit turns apparent idle detection off.
// - Apparent idle sets second flag bit 2 and phase bits 8:6 together.
// - Apparent flag sets on any entry or exit; mask bit 2 drives output.
// - In normal power mode a 32-bit checksum covers the configuration set.
// - Covered bits enter serially, lowest bit of first word first.
// - Checksum starts all ones and uses the Ethernet polynomial taps.
// - 2272 steps of feedback and tap shifting give the checksum.
// - After any reset the checksum reads the default value.
// - Covered write or silent change sets second flag bit 25.
// - Two active-low outputs, each asserted by any set and enabled flag.
// - Flags are set by events whatever the mask bits hold.
// - Writing one clears a flag; output stays low until flags clear.
// - All mask bits are zero after reset.
// - End of reset sets bit 15 and drives second output low unmasked.
module noload_crc_interrupt_unit (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire noload_crc_pkg::reg_req_t   req,
  output logic                     [31:0] reg_rdata,
  input  wire noload_crc_pkg::phase_set_t lsb_inc,
  input  wire logic                       idle_tick,
  input  wire logic                [31:0] events_first,
  input  wire logic                [31:0] events_second,
  input  wire logic                       cfg_write,
  input  wire logic                       normal_power_mode,
  input  wire logic                       cov_bit,
  output logic                     [11:0] cov_index,
  output noload_crc_pkg::phase_set_t      acc_enable,
  output logic                            checksum_busy,
  output logic                            int_out_first_n,
  output logic                            int_out_second_n
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] checksum;
    logic [31:0] mask_first;
    logic [31:0] mask_second;
    logic [31:0] flags_first;
    logic [31:0] flags_second;
    logic [2:0]  fund_idle;
    logic [2:0]  apparent_idle;
    logic [15:0] active_limit;
    logic [15:0] reactive_limit;
    logic [15:0] apparent_limit;
    logic        boot;
    logic        write_pending;
    logic        pass_had_write;
    logic [31:0] rdata;
    logic [8:0]  enables;
  } state_t;

  state_t q;
  state_t d;

  // Flag bits that this block owns in the second word.
  localparam logic [31:0] OWN_SECOND_BITS =
    (32'h1 << noload_crc_pkg::FUND_IDLE_FLAG_BIT) |
    (32'h1 << noload_crc_pkg::APPARENT_IDLE_FLAG_BIT) |
    (32'h1 << noload_crc_pkg::RESET_FINISHED_BIT) |
    (32'h1 << noload_crc_pkg::CRC_CHANGE_BIT);

  // Mask bit that can never gate the second output.
  localparam logic [31:0] UNMASKABLE_SECOND =
    32'h1 << noload_crc_pkg::RESET_FINISHED_BIT;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Decodes a write strobe to one register offset.
  function automatic logic wr_hit(input noload_crc_pkg::reg_req_t r,
                                  input logic [15:0]              ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  // New flag word: events set, written ones clear, and a set wins.
  function automatic logic [31:0] w1c(input logic [31:0] cur,
                                      input logic [31:0] clr,
                                      input logic [31:0] set);
    w1c = (cur & ~clr) | set;
  endfunction

  // --------------------------------------------------------------------
  // Idle timers for the three energy paths
  // --------------------------------------------------------------------
  logic [2:0] active_idle;
  logic [2:0] reactive_idle;
  logic [2:0] apparent_idle;

  // Each path counts ticks from its own least-significant increments.
  idle_timer u_active_timer (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .tick  (idle_tick),
    .inc   (lsb_inc.fund_active),
    .limit (q.active_limit),
    .idle  (active_idle)
  );

  idle_timer u_reactive_timer (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .tick  (idle_tick),
    .inc   (lsb_inc.fund_reactive),
    .limit (q.reactive_limit),
    .idle  (reactive_idle)
  );

  idle_timer u_apparent_timer (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .tick  (idle_tick),
    .inc   (lsb_inc.apparent),
    .limit (q.apparent_limit),
    .idle  (apparent_idle)
  );

  // --------------------------------------------------------------------
  // Checksum engine
  // --------------------------------------------------------------------
  logic        crc_busy;
  logic        crc_done;
  logic [11:0] crc_index;
  logic [31:0] crc_result;
  logic        crc_bit;
  logic        crc_start;

  // Mask words lead the covered stream; the rest comes from outside.
  always_comb
  begin
    if (crc_index < noload_crc_pkg::MASK_WORD_BITS)
      crc_bit = q.mask_first[crc_index[4:0]];
    else if (crc_index < 2 * noload_crc_pkg::MASK_WORD_BITS)
      crc_bit = q.mask_second[crc_index[4:0]];
    else
      crc_bit = cov_bit;
  end

  // Passes repeat while in normal power mode, two idle cycles apart.
  assign crc_start = normal_power_mode && !crc_done;

  crc_lfsr_engine u_crc (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .start  (crc_start),
    .bit_in (crc_bit),
    .busy   (crc_busy),
    .done   (crc_done),
    .index  (crc_index),
    .result (crc_result)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic       act_on;
  logic       rea_on;
  logic [2:0] fund_idle_now;
  logic [2:0] app_idle_now;
  logic [31:0] set_first;
  logic [31:0] set_second;
  logic [31:0] clr_first;
  logic [31:0] clr_second;
  logic        mask_written;

  // Fundamental idle needs every enabled path idle, at least one enabled.
  always_comb
  begin
    act_on = q.active_limit != noload_crc_pkg::LIMIT_RESET;
    rea_on = q.reactive_limit != noload_crc_pkg::LIMIT_RESET;
    for (int p = 0; p < 3; p++)
    begin
      fund_idle_now[p] = (act_on || rea_on) &&
                         (active_idle[p] || !act_on) &&
                         (reactive_idle[p] || !rea_on);
    end
    app_idle_now = apparent_idle;
  end

  // Event and clear vectors for both flag words.
  always_comb
  begin
    mask_written = wr_hit(req, noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK) ||
                   wr_hit(req, noload_crc_pkg::OFS_INT_OUT_SECOND_N_ENABLE_MASK);
    set_first  = events_first;
    set_second = events_second & ~OWN_SECOND_BITS;
    set_second[noload_crc_pkg::FUND_IDLE_FLAG_BIT] =
      fund_idle_now != q.fund_idle;
    set_second[noload_crc_pkg::APPARENT_IDLE_FLAG_BIT] =
      app_idle_now != q.apparent_idle;
    set_second[noload_crc_pkg::RESET_FINISHED_BIT] = q.boot;
    set_second[noload_crc_pkg::CRC_CHANGE_BIT] = crc_done &&
      (q.pass_had_write || crc_result != q.checksum);
    clr_first  = wr_hit(req, noload_crc_pkg::OFS_EVENT_FLAGS_FIRST) ?
                 req.wdata : 32'h0;
    clr_second = wr_hit(req, noload_crc_pkg::OFS_EVENT_FLAGS_SECOND) ?
                 req.wdata : 32'h0;
  end

  // Registers, phase state, checksum hold and read data.
  always_comb
  begin
    d      = q;
    d.boot = 1'b0;

    // Flags and phase bits move in the same cycle.
    d.flags_first   = w1c(q.flags_first, clr_first, set_first);
    d.flags_second  = w1c(q.flags_second, clr_second, set_second);
    d.fund_idle     = fund_idle_now;
    d.apparent_idle = app_idle_now;

    // Accumulation enables per path and phase.
    for (int p = 0; p < 3; p++)
    begin
      d.enables[6 + p] = !(fund_idle_now[p] && act_on);
      d.enables[3 + p] = !(fund_idle_now[p] && rea_on);
      d.enables[p]     = !app_idle_now[p];
    end

    // Plain register writes; the checksum has no write path.
    if (wr_hit(req, noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK))
      d.mask_first = req.wdata;
    if (wr_hit(req, noload_crc_pkg::OFS_INT_OUT_SECOND_N_ENABLE_MASK))
      d.mask_second = req.wdata;
    if (wr_hit(req, noload_crc_pkg::OFS_ACTIVE_IDLE_LIMIT))
      d.active_limit = req.wdata[15:0];
    if (wr_hit(req, noload_crc_pkg::OFS_REACTIVE_IDLE_LIMIT))
      d.reactive_limit = req.wdata[15:0];
    if (wr_hit(req, noload_crc_pkg::OFS_APPARENT_IDLE_LIMIT))
      d.apparent_limit = req.wdata[15:0];

    // A covered write is remembered until a whole pass has seen it.
    if (crc_start && !crc_busy)
    begin
      d.pass_had_write = q.write_pending || mask_written || cfg_write;
      d.write_pending  = 1'b0;
    end
    else if (mask_written || cfg_write)
      d.write_pending = 1'b1;

    // The published value changes only at the end of a full pass.
    if (crc_done)
      d.checksum = crc_result;

    // Read data, one cycle after the strobe; unmapped reads give zero.
    if (req.rd)
    begin
      case (req.addr)
        noload_crc_pkg::OFS_CONFIG_CHECKSUM:    d.rdata = q.checksum;
        noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK:   d.rdata = q.mask_first;
        noload_crc_pkg::OFS_INT_OUT_SECOND_N_ENABLE_MASK:   d.rdata = q.mask_second;
        noload_crc_pkg::OFS_EVENT_FLAGS_FIRST:  d.rdata = q.flags_first;
        noload_crc_pkg::OFS_EVENT_FLAGS_SECOND: d.rdata = q.flags_second;
        noload_crc_pkg::OFS_IDLE_PHASE_STATE:
        begin
          d.rdata = 32'h0;
          d.rdata[noload_crc_pkg::FUND_PHASE_LSB +: 3]     = q.fund_idle;
          d.rdata[noload_crc_pkg::APPARENT_PHASE_LSB +: 3] =
            q.apparent_idle;
        end
        noload_crc_pkg::OFS_ACTIVE_IDLE_LIMIT:
          d.rdata = {16'h0000, q.active_limit};
        noload_crc_pkg::OFS_REACTIVE_IDLE_LIMIT:
          d.rdata = {16'h0000, q.reactive_limit};
        noload_crc_pkg::OFS_APPARENT_IDLE_LIMIT:
          d.rdata = {16'h0000, q.apparent_limit};
        default:                                d.rdata = 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------

  // Reset loads defaults; a low clock enable freezes everything.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q                <= '0;
      q.checksum       <= noload_crc_pkg::CHECKSUM_RESET;
      q.mask_first     <= noload_crc_pkg::MASK_RESET;
      q.mask_second    <= noload_crc_pkg::MASK_RESET;
      q.flags_first    <= noload_crc_pkg::FLAGS_RESET;
      q.flags_second   <= noload_crc_pkg::FLAGS_RESET;
      q.active_limit   <= noload_crc_pkg::LIMIT_RESET;
      q.reactive_limit <= noload_crc_pkg::LIMIT_RESET;
      q.apparent_limit <= noload_crc_pkg::LIMIT_RESET;
      q.boot           <= 1'b1;
      q.enables        <= 9'h1ff;
    end
    else if (ce)
      q <= d;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------

  // Interrupt pins are gates of registered flags and masks.
  assign int_out_first_n  = ~|(q.flags_first & q.mask_first);
  assign int_out_second_n = ~|(q.flags_second &
                               (q.mask_second | UNMASKABLE_SECOND));

  assign acc_enable.fund_active   = q.enables[8:6];
  assign acc_enable.fund_reactive = q.enables[5:3];
  assign acc_enable.apparent      = q.enables[2:0];
  assign reg_rdata                = q.rdata;
  assign cov_index                = crc_index;
  assign checksum_busy            = crc_busy;

endmodule

`default_nettype wire

// *** hdl/noload_crc_pkg.sv ***
package noload_crc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets on the register port
  // ----------------------------------------------------------------------
  localparam logic [15:0] OFS_CONFIG_CHECKSUM    = 16'h0100;
  localparam logic [15:0] OFS_INT_OUT_FIRST_N_ENABLE_MASK   = 16'h0104;
  localparam logic [15:0] OFS_INT_OUT_SECOND_N_ENABLE_MASK   = 16'h0108;
  localparam logic [15:0] OFS_EVENT_FLAGS_FIRST  = 16'h010c;
  localparam logic [15:0] OFS_EVENT_FLAGS_SECOND = 16'h0110;
  localparam logic [15:0] OFS_IDLE_PHASE_STATE   = 16'h0114;
  localparam logic [15:0] OFS_ACTIVE_IDLE_LIMIT  = 16'h0118;
  localparam logic [15:0] OFS_REACTIVE_IDLE_LIMIT = 16'h011c;
  localparam logic [15:0] OFS_APPARENT_IDLE_LIMIT = 16'h0120;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [31:0] CHECKSUM_RESET = 32'haffa63b9;
  localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET    = 32'h0000_0000;
  localparam logic [15:0] LIMIT_RESET    = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions in the second flag word and the phase state register
  // ----------------------------------------------------------------------
  localparam int unsigned FUND_IDLE_FLAG_BIT     = 1;
  localparam int unsigned APPARENT_IDLE_FLAG_BIT = 2;
  localparam int unsigned RESET_FINISHED_BIT     = 15;
  localparam int unsigned CRC_CHANGE_BIT         = 25;
  localparam int unsigned FUND_PHASE_LSB         = 3;
  localparam int unsigned APPARENT_PHASE_LSB     = 6;

  // ----------------------------------------------------------------------
  // Checksum generator
  // ----------------------------------------------------------------------
  localparam logic [31:0] CRC_POLY       = 32'h04c11db7;
  localparam logic [31:0] CRC_SEED       = 32'hffff_ffff;
  localparam logic [11:0] CRC_BITS       = 12'd2272;
  localparam logic [11:0] MASK_WORD_BITS = 12'd32;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] fund_active;
    logic [2:0] fund_reactive;
    logic [2:0] apparent;
  } phase_set_t;

endpackage

// *** hdl/idle_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

// Counts ticks since a phase last added an increment; flags it idle on the first tick after the count reaches limit.
module idle_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        tick,
  input  wire logic [2:0]  inc,
  input  wire logic [15:0] limit,
  output logic      [2:0]  idle
);

  typedef struct packed {
    logic [2:0][15:0] cnt;
    logic [2:0]       idle;
  } state_t;

  state_t q;
  state_t d;

  // An increment restarts the wait; a zero limit keeps the phase active.
  always_comb
  begin
    d = q;
    for (int p = 0; p < 3; p++)
    begin
      if (inc[p] || limit == noload_crc_pkg::LIMIT_RESET)
      begin
        d.cnt[p]  = 16'h0000;
        d.idle[p] = 1'b0;
      end
      else if (tick)
      begin
        if (q.cnt[p] >= limit)
          d.idle[p] = 1'b1;
        else
          d.cnt[p] = q.cnt[p] + 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign idle = q.idle;

endmodule

`default_nettype wire

// *** hdl/crc_lfsr_engine.sv ***
`timescale 1ns/1ns
`default_nettype none

// Serial checksum generator, one input bit per enabled clock.
module crc_lfsr_engine (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        bit_in,
  output logic             busy,
  output logic             done,
  output logic      [11:0] index,
  output logic      [31:0] result
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [11:0] idx;
    logic [31:0] crc;
  } state_t;

  state_t q;
  state_t d;

  // One step: feedback is input XOR top bit, then taps fold into the shift.
  function automatic logic [31:0] crc_step(input logic [31:0] s,
                                           input logic        a);
    logic fb;
    fb = a ^ s[31];
    crc_step = {s[30:0], 1'b0} ^ (fb ? noload_crc_pkg::CRC_POLY : 32'h0);
  endfunction

  // Sequencer over all covered bits, lowest bit of the first word first.
  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    if (!q.busy)
    begin
      if (start)
      begin
        d.busy = 1'b1;
        d.idx  = 12'h000;
        d.crc  = noload_crc_pkg::CRC_SEED;
      end
    end
    else
    begin
      d.crc = crc_step(q.crc, bit_in);
      d.idx = q.idx + 12'h001;
      if (q.idx == noload_crc_pkg::CRC_BITS - 12'h001)
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign busy   = q.busy;
  assign done   = q.done;
  assign index  = q.idx;
  assign result = q.crc;

endmodule

`default_nettype wire

// *** dv/noload_crc_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checker
// ----
module noload_crc_chk (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire noload_crc_pkg::reg_req_t   req,
  input wire noload_crc_pkg::phase_set_t lsb_inc,
  input wire logic                [11:0] cov_index,
  input wire noload_crc_pkg::phase_set_t acc_enable,
  input wire logic                       checksum_busy,
  input wire logic                       int_out_first_n,
  input wire logic                       int_out_second_n
);
  // All checks run on the one clock and pause in reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_RST_OUT: assert property (
    $fell(rst) |-> int_out_first_n && acc_enable == 9'h1ff)
    else $error("Outputs wrong after reset.");
  AST_RST_DONE: assert property (
    $fell(rst) |-> ##[1:2] !int_out_second_n)
    else $error("Second output not low after reset.");
  AST_APP_EXIT: assert property (
    lsb_inc.apparent[0] |-> ##[1:3] acc_enable.apparent[0])
    else $error("Apparent enable not restored.");
  AST_FUND_EXIT: assert property (
    lsb_inc.fund_active[0] && lsb_inc.fund_reactive[0]
    |-> ##[1:3] acc_enable.fund_active[0] && acc_enable.fund_reactive[0])
    else $error("Fundamental enable not restored.");
  AST_INT0_HOLD: assert property (
    $rose(int_out_first_n) |-> $past(req.wr) &&
    ($past(req.addr) == noload_crc_pkg::OFS_EVENT_FLAGS_FIRST ||
     $past(req.addr) == noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK))
    else $error("First output released without a write.");
  AST_INT1_HOLD: assert property (
    $rose(int_out_second_n) |-> $past(rst) || $past(req.wr) &&
    ($past(req.addr) == noload_crc_pkg::OFS_EVENT_FLAGS_SECOND ||
     $past(req.addr) == noload_crc_pkg::OFS_INT_OUT_SECOND_N_ENABLE_MASK))
    else $error("Second output released without a write.");
  AST_BUSY_IDX: assert property (
    checksum_busy |-> cov_index < noload_crc_pkg::CRC_BITS &&
    (!$rose(checksum_busy) || cov_index == 12'h000))
    else $error("Checksum index out of range.");
  AST_BUSY_RUN: assert property (
    $rose(checksum_busy) |-> checksum_busy [*8])
    else $error("Checksum pass cut short.");
endmodule
`default_nettype wire

// *** dv/host_port_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----
// Host on the register port
// ----
module host_port_model (
  input  wire logic                 clk,
  output var noload_crc_pkg::reg_req_t req,
  input  wire logic          [31:0] rdata
);
  // Idle port starts quiet.
  initial
    req = 50'h0;

  // Strobes drop; address and data lines show the inverse of their last value.
  task automatic idle();
    req.wr    = 1'b0;
    req.rd    = 1'b0;
    req.addr  = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  // One write cycle, launched after a falling edge.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge clk);
    idle();
  endtask

  // One read cycle; data is taken the cycle after the strobe.
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge clk);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge clk);
    d = rdata;
    idle();
  endtask

  // Reads flags and phase state, then writes the flags back.
  task automatic service(output logic [31:0] f);
    logic [31:0] p;
    rd(noload_crc_pkg::OFS_EVENT_FLAGS_SECOND, f);
    rd(noload_crc_pkg::OFS_IDLE_PHASE_STATE, p);
    wr(noload_crc_pkg::OFS_EVENT_FLAGS_SECOND, f);
  endtask
endmodule
`default_nettype wire

// *** dv/noload_crc_interrupt_unit_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----
// Testbench
// ----
module noload_crc_interrupt_unit_tb_top;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  noload_crc_pkg::reg_req_t   req;
  logic                [31:0] rdata;
  noload_crc_pkg::phase_set_t inc = 9'h0;
  noload_crc_pkg::phase_set_t acc;
  logic                       tick = 1'b0;
  logic                [31:0] ev0 = 32'h0;
  logic                       npm = 1'b0;
  logic                       busy;
  logic                       int_out_first_n_n;
  logic                       int_out_second_n_n;
  logic                [31:0] v;
  int                         n;
  int                         fails = 0;
  int                         n_tests = 0;

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  host_port_model i_host (
    .clk   (clk),
    .req   (req),
    .rdata (rdata)
  );

  noload_crc_interrupt_unit i_dut (
    .clk               (clk),
    .rst               (rst),
    .ce                (1'b1),
    .req               (req),
    .reg_rdata         (rdata),
    .lsb_inc           (inc),
    .idle_tick         (tick),
    .events_first      (ev0),
    .events_second     (32'h0),
    .cfg_write         (1'b0),
    .normal_power_mode (npm),
    .cov_bit           (1'b0),
    .cov_index         (),
    .acc_enable        (acc),
    .checksum_busy     (busy),
    .int_out_first_n   (int_out_first_n_n),
    .int_out_second_n  (int_out_second_n_n)
  );

  // Compares and reports one value.
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // Reads a register and compares the masked value.
  task automatic rdc(input string s, input logic [15:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    i_host.rd(a, v);
    chk(s, e, v & m);
  endtask

  // Issues idle ticks, then lets the enables settle.
  task automatic ticks(input int k);
    repeat (k)
    begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
    repeat (3) @(negedge clk);
  endtask

  // Waits a bounded time for busy to reach a level.
  task automatic until_busy(input logic lvl);
    n = 0;
    while (busy !== lvl && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    // A wait that runs out counts as a mismatch.
    if (busy !== lvl)
      fails++;
  endtask

  // Prints the verdict and ends the run.
  task automatic results;
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("int_out_second_n_n", 32'h0, 32'(int_out_second_n_n));
    rdc("flags2", noload_crc_pkg::OFS_EVENT_FLAGS_SECOND, '1, 32'h8000);
    rdc("int_out_first_n_enable_mask", noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK, '1, 32'h0);
    rdc("int_out_second_n_enable_mask", noload_crc_pkg::OFS_INT_OUT_SECOND_N_ENABLE_MASK, '1, 32'h0);
    rdc("sum", noload_crc_pkg::OFS_CONFIG_CHECKSUM, '1, 32'haffa63b9);
    i_host.wr(noload_crc_pkg::OFS_CONFIG_CHECKSUM, 32'h0);
    rdc("sum ro", noload_crc_pkg::OFS_CONFIG_CHECKSUM, '1, 32'haffa63b9);
    i_host.wr(noload_crc_pkg::OFS_EVENT_FLAGS_SECOND, 32'h8000);
    chk("int_out_second_n_n clr", 32'h1, 32'(int_out_second_n_n));
    @(negedge clk);
    ev0 = 32'h20;
    @(negedge clk);
    ev0 = 32'h0;
    chk("int_out_first_n_n off", 32'h1, 32'(int_out_first_n_n));
    rdc("flags1", noload_crc_pkg::OFS_EVENT_FLAGS_FIRST, '1, 32'h20);
    i_host.wr(noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK, 32'h20);
    chk("int_out_first_n_n", 32'h0, 32'(int_out_first_n_n));
    i_host.wr(noload_crc_pkg::OFS_EVENT_FLAGS_FIRST, 32'h20);
    chk("int_out_first_n_n clr", 32'h1, 32'(int_out_first_n_n));
    i_host.wr(noload_crc_pkg::OFS_INT_OUT_SECOND_N_ENABLE_MASK, 32'h4);
    i_host.wr(noload_crc_pkg::OFS_APPARENT_IDLE_LIMIT, 32'h2);
    ticks(2);
    chk("app on", 32'h7, 32'(acc.apparent));
    ticks(1);
    chk("app off", 32'h0, 32'(acc.apparent));
    chk("int_out_second_n_n app", 32'h0, 32'(int_out_second_n_n));
    rdc("ph app", noload_crc_pkg::OFS_IDLE_PHASE_STATE, 32'h1f8, 32'h1c0);
    i_host.service(v);
    chk("flag app", 32'h4, v & 32'h4);
    inc = 9'h001;
    @(negedge clk);
    inc = 9'h0;
    ticks(0);
    chk("app exit", 32'h1, 32'(acc.apparent));
    rdc("flag exit", noload_crc_pkg::OFS_EVENT_FLAGS_SECOND, 32'h4, 32'h4);
    rdc("ph exit", noload_crc_pkg::OFS_IDLE_PHASE_STATE, 32'h1c0, 32'h180);
    i_host.wr(noload_crc_pkg::OFS_APPARENT_IDLE_LIMIT, 32'h0);
    ticks(0);
    chk("app dis", 32'h7, 32'(acc.apparent));
    i_host.wr(noload_crc_pkg::OFS_ACTIVE_IDLE_LIMIT, 32'h1);
    i_host.wr(noload_crc_pkg::OFS_REACTIVE_IDLE_LIMIT, 32'h1);
    ticks(2);
    chk("fund off", 32'h0, 32'({acc.fund_active, acc.fund_reactive}));
    rdc("ph fund", noload_crc_pkg::OFS_IDLE_PHASE_STATE, 32'h38, 32'h38);
    rdc("flag fund", noload_crc_pkg::OFS_EVENT_FLAGS_SECOND, 32'h2, 32'h2);
    i_host.wr(noload_crc_pkg::OFS_INT_OUT_SECOND_N_ENABLE_MASK, 32'h2);
    chk("int_out_second_n_n fund", 32'h0, 32'(int_out_second_n_n));
    i_host.wr(noload_crc_pkg::OFS_REACTIVE_IDLE_LIMIT, 32'h0);
    ticks(0);
    chk("fund rea", 32'h7, 32'({acc.fund_active, acc.fund_reactive}));
    inc = 9'h048;
    @(negedge clk);
    inc = 9'h0;
    ticks(0);
    chk("fund exit", 32'h1, 32'(acc.fund_active));
    npm = 1'b1;
    until_busy(1'b1);
    until_busy(1'b0);
    chk("pass len", 32'h8e0, 32'(n));
    i_host.service(v);
    i_host.wr(noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK, 32'h20);
    // The write lands mid-pass, so only the following full pass reports it.
    until_busy(1'b0);
    until_busy(1'b1);
    until_busy(1'b0);
    repeat (2) @(negedge clk);
    rdc("flag sum", noload_crc_pkg::OFS_EVENT_FLAGS_SECOND, 32'h200_0000, 32'h200_0000);
    // The host answers the checksum flag with a reset and a reload.
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("int_out_second_n_n rst", 32'h0, 32'(int_out_second_n_n));
    rdc("int_out_first_n_enable_mask rst", noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK, '1, 32'h0);
    rdc("sum rst", noload_crc_pkg::OFS_CONFIG_CHECKSUM, '1, 32'haffa63b9);
    i_host.wr(noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK, 32'h20);
    rdc("int_out_first_n_enable_mask new", noload_crc_pkg::OFS_INT_OUT_FIRST_N_ENABLE_MASK, '1, 32'h20);
    results;
  end

  // Cuts the run short if the sequence hangs.
  initial
  begin
    #1500000;
    fails++;
    results;
  end
endmodule

bind noload_crc_interrupt_unit noload_crc_chk i_chk (
  .clk              (clk),
  .rst              (rst),
  .req              (req),
  .lsb_inc          (lsb_inc),
  .cov_index        (cov_index),
  .acc_enable       (acc_enable),
  .checksum_busy    (checksum_busy),
  .int_out_first_n  (int_out_first_n),
  .int_out_second_n (int_out_second_n)
);
`default_nettype wire
